// *** hw/serial_baud_consts.svh ***
// Constants for the serial bit-rate generator and pin control block
`ifndef SERIAL_BAUD_CONSTS_SVH
`define SERIAL_BAUD_CONSTS_SVH
// ------------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ------------------------------------------------------------------
`define OFS_CHAN1_DIVISOR    4'h0
`define OFS_CHAN2_DIVISOR    4'h1
`define OFS_CHAN1_PRESCALE   4'h2
`define OFS_CHAN2_PRESCALE   4'h3
`define OFS_CLOCK_STOP_1     4'h4
`define OFS_PIN_CONTROL      4'h5
`define OFS_GEN_STATUS       4'h6
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_DIVISOR          8'hFF
`define RST_PRESCALE         2'h0
`define RST_CLOCK_STOP_1     8'hFF
`define RST_PIN_CONTROL      8'hC0
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_CHAN1_RUN        6
`define BIT_CHAN2_RUN        5
`define BIT_CHAN2_TX_SEL     5
`define BIT_CHAN1_TX_SEL     4
`define BIT_CHAN2_TX_INV     3
`define BIT_CHAN2_RX_INV     2
`define BIT_CHAN1_TX_INV     1
`define BIT_CHAN1_RX_INV     0
`define PIN_CONTROL_FIXED    8'hC0
`define PIN_CONTROL_WMASK    8'h3F
// ------------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------------
`define PRE16_MASK           6'h0F
`define PRE64_MASK           6'h3F
`define ASYNC_PHASE_LAST     6'h3F
`define ASYNC_SAMPLE_MASK    6'h03
`define SYNC_PHASE_MASK      6'h07
`endif

// *** hw/serial_baud_pkg.sv ***
// Types for the serial bit-rate generator and pin control block
package serial_baud_pkg;

  typedef enum logic [1:0] {
    PRE_SYSTEM   = 2'b00,
    PRE_SUBCLOCK = 2'b01,
    PRE_DIV16    = 2'b10,
    PRE_DIV64    = 2'b11
  } prescale_sel_t;

  typedef struct packed {
    logic [1:0][7:0] divisor;
    logic [1:0][1:0] prescale;
    logic [7:0]      clock_stop;
    logic [7:0]      pin_control;
    logic [5:0]      pre_cnt;
    logic            sub_half;
    logic [1:0][7:0] div_cnt;
    logic [1:0][5:0] phase;
    logic [1:0]      sample_tick;
    logic [1:0]      bit_tick;
    logic [7:0]      rdata;
    logic [1:0]      tx_out;
    logic [1:0]      tx_oe_n;
    logic [1:0]      rx_data;
  } state_t;

endpackage : serial_baud_pkg

// *** hw/serial_baud_and_pin_control.sv ***
// Bit-rate generators, module standby and pin control for two serial channels
`timescale 1ns/1ps
`default_nettype none
`include "serial_baud_consts.svh"

// Summary of operation
// - Divisor resets to FF, also in standby
// - Divisor readable at any time, writable only while the channel runs outside standby
// - Asynchronous rate: input over 64 times N+1
// - Synchronous rate: input over 8 times N+1
// - Prescale select picks system, sub, /16, /64
// - Sub-clock halved unless in subactive/subsleep
// - Eight module-stop bits reset to one, RW
// - Bit 6 low stops first channel
// - Standby forces both channels' registers to reset
// - Bit 5 low stops and resets second channel
// - Pin control register resets to C0
// - Pin control bits 7,6 read one, ignore writes
// - Bit 5 routes pin to channel 2 transmit
// - Bit 4 routes pin to channel 1 transmit
// - Bit 3 inverts channel 2 transmit data
// - Bit 2 inverts channel 2 receive data
// - Bit 1 inverts channel 1 transmit data
// - Bit 0 inverts channel 1 receive data
// - External serial clock idles internal generator
module serial_baud_and_pin_control (
  input  wire logic       CLOCK,            // System clock
  input  wire logic       RESET_N,          // Asynchronous reset, active low
  input  wire logic [3:0] REG_ADDR,         // Register byte address
  input  wire logic [7:0] REG_WDATA,        // Register write data
  input  wire logic       REG_WRITE,        // Write strobe
  input  wire logic       REG_READ,         // Read strobe
  output logic      [7:0] REG_RDATA,        // Read data, cycle after strobe
  input  wire logic       SUB_CLK_TICK,     // One pulse per sub-clock period
  input  wire logic       SUB_MODE,         // Subactive or subsleep active
  input  wire logic       STANDBY_MODE,     // Standby or watch mode active
  input  wire logic [1:0] CHAN_SYNC_MODE,   // Per channel: 1 synchronous
  input  wire logic [1:0] CHAN_EXT_CLOCK,   // Per channel: external clock used
  output logic      [1:0] CHAN_MODULE_RESET,// Per channel: hold engine reset
  output logic      [1:0] CHAN_SAMPLE_TICK, // Per channel: 16x tick, async
  output logic      [1:0] CHAN_BIT_TICK,    // Per channel: bit-rate tick
  input  wire logic [1:0] CHAN_TX_DATA,     // Per channel: engine transmit data
  input  wire logic [1:0] PORT_OUT,         // Per pin: general I/O output level
  input  wire logic [1:0] PORT_OE_N,        // Per pin: general I/O enable, low
  output logic      [1:0] TX_PIN_OUT,       // Per pin: shared pin output level
  output logic      [1:0] TX_PIN_OE_N,      // Per pin: shared pin enable, low
  input  wire logic [1:0] RX_PIN,           // Per channel: receive pin level
  output logic      [1:0] CHAN_RX_DATA      // Per channel: receive data to engine
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  serial_baud_pkg::state_t state_ff;
  serial_baud_pkg::state_t nxt_state;

  logic [1:0] chan_run;
  logic [1:0] pre_tick;
  logic [1:0] tx_sel;
  logic [1:0] tx_inv;
  logic [1:0] rx_inv;
  logic       tick16;
  logic       tick64;

  // ------------------------------------------------------------------
  // Decoded controls
  // ------------------------------------------------------------------
  always_comb
  begin
    chan_run[0] = state_ff.clock_stop[`BIT_CHAN1_RUN];
    chan_run[1] = state_ff.clock_stop[`BIT_CHAN2_RUN];
    tx_sel[0]   = state_ff.pin_control[`BIT_CHAN1_TX_SEL];
    tx_sel[1]   = state_ff.pin_control[`BIT_CHAN2_TX_SEL];
    tx_inv[0]   = state_ff.pin_control[`BIT_CHAN1_TX_INV];
    tx_inv[1]   = state_ff.pin_control[`BIT_CHAN2_TX_INV];
    rx_inv[0]   = state_ff.pin_control[`BIT_CHAN1_RX_INV];
    rx_inv[1]   = state_ff.pin_control[`BIT_CHAN2_RX_INV];
    tick16      = ((state_ff.pre_cnt & `PRE16_MASK) == `PRE16_MASK);
    tick64      = (state_ff.pre_cnt == `PRE64_MASK);
  end

  // ------------------------------------------------------------------
  // Prescaler input selection per channel
  // ------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      case (serial_baud_pkg::prescale_sel_t'(state_ff.prescale[i]))
        serial_baud_pkg::PRE_SYSTEM:   pre_tick[i] = 1'b1;
        serial_baud_pkg::PRE_SUBCLOCK: pre_tick[i] = SUB_CLK_TICK &
                                                     (SUB_MODE | state_ff.sub_half);
        serial_baud_pkg::PRE_DIV16:    pre_tick[i] = tick16;
        serial_baud_pkg::PRE_DIV64:    pre_tick[i] = tick64;
        default:                       pre_tick[i] = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_state             = state_ff;
    nxt_state.sample_tick = 2'b00;
    nxt_state.bit_tick    = 2'b00;
    nxt_state.rdata       = 8'h00;
    nxt_state.pre_cnt     = 6'(state_ff.pre_cnt + 6'h01);
    if (SUB_CLK_TICK)
    begin
      nxt_state.sub_half = ~state_ff.sub_half;
    end

    // Register writes; divisor and prescale writes are lost while the channel is stopped or in standby
    if (REG_WRITE)
    begin
      case (REG_ADDR)
        `OFS_CHAN1_DIVISOR:  nxt_state.divisor[0]  = REG_WDATA;
        `OFS_CHAN2_DIVISOR:  nxt_state.divisor[1]  = REG_WDATA;
        `OFS_CHAN1_PRESCALE: nxt_state.prescale[0] = REG_WDATA[1:0];
        `OFS_CHAN2_PRESCALE: nxt_state.prescale[1] = REG_WDATA[1:0];
        `OFS_CLOCK_STOP_1:   nxt_state.clock_stop  = REG_WDATA;
        `OFS_PIN_CONTROL:    nxt_state.pin_control = `PIN_CONTROL_FIXED |
                                                     (REG_WDATA & `PIN_CONTROL_WMASK);
        default:             nxt_state.rdata       = 8'h00;
      endcase
    end

    // Register reads, data stands in the following cycle only
    if (REG_READ)
    begin
      case (REG_ADDR)
        `OFS_CHAN1_DIVISOR:  nxt_state.rdata = state_ff.divisor[0];
        `OFS_CHAN2_DIVISOR:  nxt_state.rdata = state_ff.divisor[1];
        `OFS_CHAN1_PRESCALE: nxt_state.rdata = {6'h00, state_ff.prescale[0]};
        `OFS_CHAN2_PRESCALE: nxt_state.rdata = {6'h00, state_ff.prescale[1]};
        `OFS_CLOCK_STOP_1:   nxt_state.rdata = state_ff.clock_stop;
        `OFS_PIN_CONTROL:    nxt_state.rdata = state_ff.pin_control | `PIN_CONTROL_FIXED;
        `OFS_GEN_STATUS:     nxt_state.rdata = {4'h0, STANDBY_MODE, SUB_MODE,
                                                chan_run & ~CHAN_EXT_CLOCK};
        default:             nxt_state.rdata = 8'h00;
      endcase
    end

    // Bit-rate generators
    for (int i = 0; i < 2; i++)
    begin
      if (!chan_run[i] || STANDBY_MODE)
      begin
        // Module standby and chip standby return the channel to reset values
        nxt_state.divisor[i]  = `RST_DIVISOR;
        nxt_state.prescale[i] = `RST_PRESCALE;
        nxt_state.div_cnt[i]  = `RST_DIVISOR;
        nxt_state.phase[i]    = 6'h00;
      end
      else if (CHAN_EXT_CLOCK[i])
      begin
        // Generator parked while the channel times from its external clock
        nxt_state.div_cnt[i] = state_ff.divisor[i];
        nxt_state.phase[i]   = 6'h00;
      end
      else if (pre_tick[i])
      begin
        if (state_ff.div_cnt[i] == 8'h00)
        begin
          nxt_state.div_cnt[i] = state_ff.divisor[i];
          nxt_state.phase[i]   = 6'(state_ff.phase[i] + 6'h01);
          if (CHAN_SYNC_MODE[i])
          begin
            nxt_state.bit_tick[i] = ((state_ff.phase[i] & `SYNC_PHASE_MASK)
                                     == `SYNC_PHASE_MASK);
          end
          else
          begin
            nxt_state.sample_tick[i] = ((state_ff.phase[i] & `ASYNC_SAMPLE_MASK)
                                        == `ASYNC_SAMPLE_MASK);
            nxt_state.bit_tick[i]    = (state_ff.phase[i] == `ASYNC_PHASE_LAST);
          end
        end
        else
        begin
          nxt_state.div_cnt[i] = 8'(state_ff.div_cnt[i] - 8'h01);
        end
      end
    end

    // Pin function and inversion
    for (int i = 0; i < 2; i++)
    begin
      if (tx_sel[i])
      begin
        nxt_state.tx_out[i]  = CHAN_TX_DATA[i] ^ tx_inv[i];
        nxt_state.tx_oe_n[i] = 1'b0;
      end
      else
      begin
        nxt_state.tx_out[i]  = PORT_OUT[i];
        nxt_state.tx_oe_n[i] = PORT_OE_N[i];
      end
      nxt_state.rx_data[i] = RX_PIN[i] ^ rx_inv[i];
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_ff.divisor     <= {`RST_DIVISOR, `RST_DIVISOR};
      state_ff.prescale    <= {`RST_PRESCALE, `RST_PRESCALE};
      state_ff.clock_stop  <= `RST_CLOCK_STOP_1;
      state_ff.pin_control <= `RST_PIN_CONTROL;
      state_ff.pre_cnt     <= 6'h00;
      state_ff.sub_half    <= 1'b0;
      state_ff.div_cnt     <= {`RST_DIVISOR, `RST_DIVISOR};
      state_ff.phase       <= 12'h000;
      state_ff.sample_tick <= 2'b00;
      state_ff.bit_tick    <= 2'b00;
      state_ff.rdata       <= 8'h00;
      state_ff.tx_out      <= 2'b11;
      state_ff.tx_oe_n     <= 2'b11;
      state_ff.rx_data     <= 2'b11;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  always_comb
  begin
    REG_RDATA         = state_ff.rdata;
    CHAN_MODULE_RESET = ~chan_run | {2{STANDBY_MODE}};
    CHAN_SAMPLE_TICK  = state_ff.sample_tick;
    CHAN_BIT_TICK     = state_ff.bit_tick;
    TX_PIN_OUT        = state_ff.tx_out;
    TX_PIN_OE_N       = state_ff.tx_oe_n;
    CHAN_RX_DATA      = state_ff.rx_data;
  end

endmodule : serial_baud_and_pin_control
`default_nettype wire

// *** hw/placeholder_none.sv ***
// Empty unit kept for compile order; holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** testbench/serial_remote_model.sv ***
// Remote serial device: drives receive lines, sees transmit lines
`timescale 1ns/1ps
`default_nettype none
module serial_remote_model (
  input  wire logic [1:0] tx_out,  // Pin output level
  input  wire logic [1:0] tx_oe_n, // Pin enable, low
  input  wire logic [1:0] send,    // Levels to send
  output logic      [1:0] line_rx, // Receive lines
  output logic      [1:0] line_tx  // Transmit lines as seen
);
  // Released pins float to the pull-up level
  assign line_tx = (~tx_oe_n & tx_out) | tx_oe_n;
  assign line_rx = send;
endmodule : serial_remote_model
`default_nettype wire

// *** testbench/serial_baud_and_pin_control_chk.sv ***
// Port assertions for the bit-rate and pin control block
`timescale 1ns/1ps
`default_nettype none
`include "serial_baud_consts.svh"
module serial_baud_chk (
  input wire logic       CLOCK,             // Clock
  input wire logic       RESET_N,           // Reset, active low
  input wire logic [3:0] REG_ADDR,          // Address
  input wire logic       REG_READ,          // Read strobe
  input wire logic [7:0] REG_RDATA,         // Read data
  input wire logic       STANDBY_MODE,      // Standby
  input wire logic [1:0] CHAN_SYNC_MODE,    // Sync mode
  input wire logic [1:0] CHAN_EXT_CLOCK,    // External clock
  input wire logic [1:0] CHAN_MODULE_RESET, // Channel reset
  input wire logic [1:0] CHAN_SAMPLE_TICK,  // Sample tick
  input wire logic [1:0] CHAN_BIT_TICK,     // Bit tick
  input wire logic [1:0] PORT_OE_N,         // Port enable
  input wire logic [1:0] TX_PIN_OE_N        // Pin enable
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  read_idle_a: assert property (!$past(REG_READ) |-> REG_RDATA == 8'h00)
    else $error("read data not idle");
  fixed_ones_a: assert property ($past(REG_READ) && $past(REG_ADDR) == `OFS_PIN_CONTROL
    |-> REG_RDATA[7:6] == 2'b11) else $error("pin control top bits not one");
  standby_div_a: assert property ($past(REG_READ) && $past(REG_ADDR) <= 4'h1
    && $past(STANDBY_MODE) && $past(STANDBY_MODE, 2) |-> REG_RDATA == 8'hFF)
    else $error("divisor not FF");
  standby_rst_a: assert property (STANDBY_MODE |-> CHAN_MODULE_RESET == 2'b11)
    else $error("standby without channel reset");
  stop_tick_a: assert property (CHAN_MODULE_RESET[0] |=> CHAN_BIT_TICK[0] == 1'b0)
    else $error("tick while stopped");
  ext_park_a: assert property (CHAN_EXT_CLOCK[1] |=> CHAN_BIT_TICK[1] == 1'b0
    && CHAN_SAMPLE_TICK[1] == 1'b0) else $error("tick with external clock");
  sync_space_a: assert property (CHAN_BIT_TICK[0] && CHAN_SYNC_MODE[0]
    |=> !CHAN_BIT_TICK[0] [*7]) else $error("sync ticks too close");
  samp_space_a: assert property ($rose(CHAN_SAMPLE_TICK[0]) |=> !CHAN_SAMPLE_TICK[0] [*3])
    else $error("sample ticks too close");
  oe_route_a: assert property (PORT_OE_N[1] == 1'b0 |=> TX_PIN_OE_N[1] == 1'b0)
    else $error("pin not driven");
endmodule : serial_baud_chk
bind serial_baud_and_pin_control serial_baud_chk i_chk (.CLOCK, .RESET_N, .REG_ADDR,
  .REG_READ, .REG_RDATA, .STANDBY_MODE, .CHAN_SYNC_MODE, .CHAN_EXT_CLOCK, .CHAN_MODULE_RESET,
  .CHAN_SAMPLE_TICK, .CHAN_BIT_TICK, .PORT_OE_N, .TX_PIN_OE_N);
`default_nettype wire

// *** testbench/serial_baud_and_pin_control_test.sv ***
// Self-checking bench for the bit-rate and pin control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module serial_baud_and_pin_control_test;
  logic       CLOCK, RESET_N, REG_WRITE, REG_READ, SUB_CLK_TICK, SUB_MODE, STANDBY_MODE;
  logic [3:0] REG_ADDR;
  logic [7:0] REG_WDATA, REG_RDATA;
  logic [1:0] CHAN_SYNC_MODE, CHAN_EXT_CLOCK, CHAN_MODULE_RESET, CHAN_SAMPLE_TICK;
  logic [1:0] CHAN_BIT_TICK, CHAN_TX_DATA, PORT_OUT, PORT_OE_N, TX_PIN_OUT, TX_PIN_OE_N;
  logic [1:0] RX_PIN, CHAN_RX_DATA, send, line_tx, sub_cnt;
  int         err_total, check_count;
  serial_baud_and_pin_control i_dut (.CLOCK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WRITE,
    .REG_READ, .REG_RDATA, .SUB_CLK_TICK, .SUB_MODE, .STANDBY_MODE, .CHAN_SYNC_MODE,
    .CHAN_EXT_CLOCK, .CHAN_MODULE_RESET, .CHAN_SAMPLE_TICK, .CHAN_BIT_TICK, .CHAN_TX_DATA,
    .PORT_OUT, .PORT_OE_N, .TX_PIN_OUT, .TX_PIN_OE_N, .RX_PIN, .CHAN_RX_DATA);
  serial_remote_model i_rem (.tx_out(TX_PIN_OUT), .tx_oe_n(TX_PIN_OE_N), .send(send),
    .line_rx(RX_PIN), .line_tx(line_tx));
  initial
  begin
    CLOCK = 1'b0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  // Sub-clock pulse every fourth system clock
  always @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      sub_cnt <= 2'h0;
      SUB_CLK_TICK <= 1'b0;
    end
    else
    begin
      sub_cnt <= sub_cnt + 2'h1;
      SUB_CLK_TICK <= (sub_cnt == 2'h3);
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge CLOCK);
    REG_WRITE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_READ <= 1'b1;
    @(posedge CLOCK);
    REG_READ <= 1'b0;
    #1 `CHK(REG_RDATA, e)
  endtask : rd
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic t_regs;
    rd(4'h0, 8'hFF);
    rd(4'h1, 8'hFF);
    rd(4'h4, 8'hFF);
    rd(4'h5, 8'hC0);
    wr(4'h0, 8'h5A);
    rd(4'h0, 8'h5A);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hC0);
    wr(4'hF, 8'h12);
    rd(4'hF, 8'h00);
    wr(4'h1, 8'h33);
    wr(4'h4, 8'hDF);
    #1 `CHK(CHAN_MODULE_RESET, 2'b10)
    rd(4'h1, 8'hFF);
    rd(4'h0, 8'h5A);
    wr(4'h4, 8'hBF);
    #1 `CHK(CHAN_MODULE_RESET, 2'b01)
    rd(4'h0, 8'hFF);
    rd(4'h4, 8'hBF);
    wr(4'h4, 8'hFF);
    wr(4'h1, 8'h33);
    @(posedge CLOCK);
    STANDBY_MODE <= 1'b1;
    rd(4'h1, 8'hFF);
    `CHK(CHAN_MODULE_RESET, 2'b11)
    STANDBY_MODE <= 1'b0;
    $display("t_regs done");
  endtask : t_regs
  task automatic t_pins;
    logic [7:0] ctl [4];
    logic [1:0] s, d, eo;
    ctl = '{8'h00, 8'h3F, 8'h19, 8'h26};
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h5, ctl[i]);
      rd(4'h5, ctl[i] | 8'hC0);
      for (int v = 0; v < 4; v++)
      begin
        d = 2'(v);
        s = {ctl[i][5], ctl[i][4]};
        @(posedge CLOCK);
        CHAN_TX_DATA <= d;
        PORT_OUT <= ~d;
        PORT_OE_N <= d;
        send <= d;
        repeat (2) @(posedge CLOCK);
        eo = (s & (d ^ {ctl[i][3], ctl[i][1]})) | (~s & ~d);
        #1 `CHK(TX_PIN_OUT, eo)
        `CHK(line_tx, eo | (~s & d))
        `CHK(TX_PIN_OE_N, ~s & d)
        `CHK(CHAN_RX_DATA, d ^ {ctl[i][2], ctl[i][0]})
      end
    end
    $display("t_pins done");
  endtask : t_pins
  // Measures the third tick interval after a new rate setting
  task automatic rate(input int ch, input logic sy, input logic [7:0] sel, input logic [7:0] n,
                      input logic sm, input logic sb, input int e);
    int k;
    wr(4'(ch), n);
    wr(4'(2 + ch), sel);
    // Park the generator for one cycle so every run starts from a reload
    CHAN_SYNC_MODE <= ch ? {sy, CHAN_SYNC_MODE[0]} : {CHAN_SYNC_MODE[1], sy};
    CHAN_EXT_CLOCK <= ch ? 2'b10 : 2'b01;
    SUB_MODE <= sb;
    @(posedge CLOCK);
    CHAN_EXT_CLOCK <= 2'b00;
    repeat (3)
    begin
      k = 0;
      do
      begin
        @(posedge CLOCK);
        #1 k++;
      end while ((sm ? CHAN_SAMPLE_TICK[ch] : CHAN_BIT_TICK[ch]) !== 1'b1 && k < 4000);
    end
    `CHK(k, e)
  endtask : rate
  task automatic t_rate;
    int k;
    rate(0, 1'b1, 8'h00, 8'h02, 1'b0, 1'b0, 24);
    rate(0, 1'b0, 8'h00, 8'h01, 1'b1, 1'b0, 8);
    rate(0, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0, 128);
    rate(1, 1'b1, 8'h02, 8'h00, 1'b0, 1'b0, 128);
    rate(1, 1'b1, 8'h03, 8'h00, 1'b0, 1'b0, 512);
    rate(0, 1'b1, 8'h01, 8'h00, 1'b0, 1'b0, 64);
    rate(0, 1'b1, 8'h01, 8'h00, 1'b0, 1'b1, 32);
    k = 0;
    @(posedge CLOCK);
    CHAN_EXT_CLOCK <= 2'b11;
    @(posedge CLOCK);
    repeat (600)
    begin
      @(posedge CLOCK);
      #1 if (CHAN_BIT_TICK !== 2'b00) k++;
    end
    `CHK(k, 0)
    $display("t_rate done");
  endtask : t_rate
  initial
  begin
    {RESET_N, REG_WRITE, REG_READ, SUB_MODE, STANDBY_MODE} = '0;
    {REG_ADDR, REG_WDATA, CHAN_SYNC_MODE, CHAN_EXT_CLOCK} = '0;
    {CHAN_TX_DATA, PORT_OUT, PORT_OE_N, send} = '0;
    err_total = 0;
    check_count = 0;
    repeat (16) @(posedge CLOCK);
    RESET_N <= 1'b1;
    t_regs;
    t_pins;
    t_rate;
    end_sim;
  end
  initial
  begin
    #500000;
    err_total++;
    end_sim;
  end
endmodule : serial_baud_and_pin_control_test
`default_nettype wire
